// [include/event_queue_pkg.sv]
// constants, register map and types for the event report queue block
// assumes a single 100 MHz device clock and a same-clock host access port
package event_queue_pkg;

	// ============================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int HOLD_TIME_NS = 1600;
	localparam logic [7:0] HOLD_CYCLES = 8'((HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ============================================================
	// internal addresses and i/o offsets
	localparam logic [11:0] ADDR_INT_NUM = 12'h022;
	localparam logic [11:0] ADDR_RX_CONFIG = 12'h102;
	localparam logic [11:0] ADDR_RX_ACCEPT = 12'h104;
	localparam logic [11:0] ADDR_LINE_CTL = 12'h112;
	localparam logic [11:0] ADDR_BUS_CTL = 12'h116;
	localparam logic [11:0] ADDR_QUEUE = 12'h120;
	localparam logic [11:0] ADDR_RX_EVENT = 12'h124;
	localparam logic [11:0] ADDR_TX_EVENT = 12'h128;
	localparam logic [11:0] ADDR_BUF_EVENT = 12'h12c;
	localparam logic [11:0] ADDR_MISS_CNT = 12'h130;
	localparam logic [11:0] ADDR_COL_CNT = 12'h132;
	localparam logic [11:0] IO_QUEUE_OFS = 12'h008;

	// ============================================================
	// report word layout
	localparam logic [5:0] REGNUM_RX = 6'h04;
	localparam logic [5:0] REGNUM_TX = 6'h08;
	localparam logic [5:0] REGNUM_BUF = 6'h0c;
	localparam logic [5:0] REGNUM_MISS = 6'h10;
	localparam logic [5:0] REGNUM_COL = 6'h12;
	localparam int NUM_SRC = 5;
	localparam int QDEPTH = 4;
	localparam logic [15:0] NULL_WORD = 16'h0000;
	// rx report content positions (register bit minus six)
	localparam int RXF_GOOD = 2;
	localparam int RXF_BAD = 6;
	localparam int RXF_SHORT = 7;
	localparam int RXF_LONG = 8;

	// ============================================================
	// register fields
	localparam int BIT_GLOBAL_IRQ = 15;
	localparam int BIT_SERIAL_RX = 6;
	localparam int BIT_FORCE_AUI = 8;
	localparam int BIT_AUTO_PORT = 9;
	localparam int BIT_LOW_SQUELCH = 14;
	localparam int BIT_ACC_IND_HASH = 6;
	localparam int BIT_ACC_ALL = 7;
	localparam int BIT_ACC_GOOD = 8;
	localparam int BIT_ACC_GROUP = 9;
	localparam int BIT_ACC_OWN = 10;
	localparam int BIT_ACC_BCAST = 11;
	localparam int BIT_ACC_BAD = 12;
	localparam int BIT_ACC_SHORT = 13;
	localparam int BIT_ACC_LONG = 14;
	localparam int BIT_BUFFER_FCS = 11;
	localparam int BIT_IE_GOOD = 8;
	localparam int BIT_IE_BAD = 12;
	localparam int BIT_IE_SHORT = 13;
	localparam int BIT_IE_LONG = 14;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// interrupt number register: 0..3 select a line, anything above floats all
	localparam int NUM_IRQ_LINES = 4;
	localparam logic [2:0] INT_NUM_FLOAT = 3'h4;
	localparam logic [2:0] INT_NUM_RESET = 3'h4;

	// ============================================================
	// frame lengths in bytes
	localparam logic [10:0] MIN_FRAME = 11'd64;
	localparam logic [10:0] MAX_FRAME = 11'd1518;
	localparam logic [10:0] FCS_BYTES = 11'd4;
	localparam logic [10:0] ALIGN_ADD = 11'd3;
	localparam logic [10:0] ALIGN_MASK = 11'h7fc;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ASSERTED = 2'b01,
		ST_HOLD = 2'b11
	} irq_state_t;

endpackage : event_queue_pkg

// [src/event_queue_rx_config.sv]
// event report queue with interrupt line control and receive configuration
// assumes host strobes are one-cycle pulses from logic on SYS_CLK_I
//
// What this block does
// - enabled event sets bits, queues report, raises line
// - first read lowers line; low 1.6us, rises again if reports pending
// - many rx/tx reports; one buffer, miss, collision
// - reports leave rx, tx, buffer, miss, collision order
// - queue read clears that register, advances queue
// - queue at 0120h memory, offset 0008h i/o
// - word holds register number low, contents high
// - interrupt number selects line or floats all
// - no interrupt without global enable bit F
// - only DA through FCS transferred; FCS optional
// - lengths in bytes, padded to double word
// - line control: rx enable, forced AUI, auto select
// - line control bit E lowers squelch level
// - address class bits choose accepted destinations
// - length and check criteria also gate acceptance
// - long frames accepted, only 1518 bytes buffered
// - rx config bits enable per-status interrupts
// - no rx status interrupt when address filter fails
// - event bits cleared only by host read
module event_queue_rx_config
	import event_queue_pkg::*;
(
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	input wire logic HOST_IO_SEL_I,
	input wire logic [11:0] HOST_ADDR_I,
	input wire logic HOST_RD_I,
	input wire logic HOST_WR_I,
	input wire logic [15:0] HOST_WDATA_I,
	input wire logic RX_FRAME_DONE_I,
	input wire logic RX_DA_PASS_I,
	input wire logic RX_IND_HASH_I,
	input wire logic RX_GROUP_HASH_I,
	input wire logic RX_OWN_MATCH_I,
	input wire logic RX_ALL_ONES_I,
	input wire logic RX_CRC_OK_I,
	input wire logic [10:0] RX_LEN_I,
	input wire logic TX_EVENT_I,
	input wire logic [9:0] TX_BITS_I,
	input wire logic BUF_EVENT_I,
	input wire logic [9:0] BUF_BITS_I,
	input wire logic MISS_OVF_I,
	input wire logic [9:0] MISS_BITS_I,
	input wire logic COL_OVF_I,
	input wire logic [9:0] COL_BITS_I,
	input wire logic TP_LINK_OK_I,
	output logic [15:0] HOST_RDATA_O,
	output logic [event_queue_pkg::NUM_IRQ_LINES-1:0] IRQ_O,
	output logic [event_queue_pkg::NUM_IRQ_LINES-1:0] IRQ_OE_O,
	output logic RX_SERIAL_EN_O,
	output logic RX_PORT_AUI_O,
	output logic RX_LOW_SQUELCH_O,
	output logic RX_ACCEPT_O,
	output logic [10:0] RX_XFER_BYTES_O,
	output logic [10:0] RX_XFER_PADDED_O
);
	import event_queue_pkg::*;

	function automatic logic [5:0] regnum(input int g);
		case (g)
			0: regnum = REGNUM_RX;
			1: regnum = REGNUM_TX;
			2: regnum = REGNUM_BUF;
			3: regnum = REGNUM_MISS;
			default: regnum = REGNUM_COL;
		endcase
	endfunction : regnum

	function automatic logic [11:0] src_addr(input int g);
		case (g)
			0: src_addr = ADDR_RX_EVENT;
			1: src_addr = ADDR_TX_EVENT;
			2: src_addr = ADDR_BUF_EVENT;
			3: src_addr = ADDR_MISS_CNT;
			default: src_addr = ADDR_COL_CNT;
		endcase
	endfunction : src_addr

	// ============================================================
	// host access decode
	logic mem_rd, mem_wr, q_rd;
	logic [15:0] line_ctl_q, rx_accept_q, rx_config_q, bus_ctl_q;
	logic [2:0] int_num_q;
	logic gie;

	assign mem_rd = HOST_RD_I && !HOST_IO_SEL_I;
	assign mem_wr = HOST_WR_I && !HOST_IO_SEL_I;
	assign q_rd = HOST_RD_I && (HOST_IO_SEL_I ? HOST_ADDR_I == IO_QUEUE_OFS : HOST_ADDR_I == ADDR_QUEUE);
	assign gie = bus_ctl_q[BIT_GLOBAL_IRQ];

	// cleared at reset, interrupt number set to float; software loads them again afterwards
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			line_ctl_q <= REG_RESET;
			rx_accept_q <= REG_RESET;
			rx_config_q <= REG_RESET;
			bus_ctl_q <= REG_RESET;
			int_num_q <= INT_NUM_RESET;
		end else if (mem_wr) begin
			case (HOST_ADDR_I)
				ADDR_LINE_CTL: line_ctl_q <= HOST_WDATA_I;
				ADDR_RX_ACCEPT: rx_accept_q <= HOST_WDATA_I;
				ADDR_RX_CONFIG: rx_config_q <= HOST_WDATA_I;
				ADDR_BUS_CTL: bus_ctl_q <= HOST_WDATA_I;
				ADDR_INT_NUM: int_num_q <= HOST_WDATA_I[2:0];
				default: ;
			endcase
		end
	end

	// ============================================================
	// receive frame classification
	logic rx_good, rx_bad, rx_short, rx_long, rx_addr_ok, rx_crit_ok;
	logic [9:0] rx_bits;

	assign rx_short = RX_LEN_I < MIN_FRAME;
	assign rx_long = RX_LEN_I > MAX_FRAME;
	assign rx_bad = !RX_CRC_OK_I;
	assign rx_good = RX_CRC_OK_I && !rx_short && !rx_long;
	assign rx_addr_ok = rx_accept_q[BIT_ACC_ALL]
		|| (RX_IND_HASH_I && rx_accept_q[BIT_ACC_IND_HASH])
		|| (RX_GROUP_HASH_I && rx_accept_q[BIT_ACC_GROUP])
		|| (RX_OWN_MATCH_I && rx_accept_q[BIT_ACC_OWN])
		|| (RX_ALL_ONES_I && rx_accept_q[BIT_ACC_BCAST]);
	assign rx_crit_ok = (rx_good && rx_accept_q[BIT_ACC_GOOD])
		|| (rx_bad && rx_accept_q[BIT_ACC_BAD])
		|| (rx_short && rx_accept_q[BIT_ACC_SHORT])
		|| (rx_long && rx_accept_q[BIT_ACC_LONG]);

	always_comb begin
		rx_bits = '0;
		rx_bits[RXF_GOOD] = rx_good && rx_config_q[BIT_IE_GOOD];
		rx_bits[RXF_BAD] = rx_bad && rx_config_q[BIT_IE_BAD];
		rx_bits[RXF_SHORT] = rx_short && rx_config_q[BIT_IE_SHORT];
		rx_bits[RXF_LONG] = rx_long && rx_config_q[BIT_IE_LONG];
	end

	// transfer length: frame data only, clipped, fcs optional, padded
	logic [10:0] rx_clip, rx_xfer;
	assign rx_clip = rx_long ? MAX_FRAME : RX_LEN_I;
	assign rx_xfer = rx_config_q[BIT_BUFFER_FCS] ? rx_clip : rx_clip - FCS_BYTES;

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RX_ACCEPT_O <= 1'b0;
			RX_XFER_BYTES_O <= '0;
			RX_XFER_PADDED_O <= '0;
		end else if (RX_FRAME_DONE_I) begin
			RX_ACCEPT_O <= RX_DA_PASS_I && rx_addr_ok && rx_crit_ok;
			RX_XFER_BYTES_O <= rx_xfer;
			RX_XFER_PADDED_O <= (rx_xfer + ALIGN_ADD) & ALIGN_MASK;
		end
	end

	// ============================================================
	// link sense synchroniser and line control outputs
	logic link_s1_q, link_s2_q, link_s3_q, link_q;

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			link_s1_q <= 1'b0;
			link_s2_q <= 1'b0;
			link_s3_q <= 1'b0;
			link_q <= 1'b0;
		end else begin
			link_s1_q <= TP_LINK_OK_I;
			link_s2_q <= link_s1_q;
			link_s3_q <= link_s2_q;
			if (link_s2_q == link_s3_q) begin
				link_q <= link_s3_q;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RX_SERIAL_EN_O <= 1'b0;
			RX_PORT_AUI_O <= 1'b0;
			RX_LOW_SQUELCH_O <= 1'b0;
		end else begin
			RX_SERIAL_EN_O <= line_ctl_q[BIT_SERIAL_RX];
			RX_PORT_AUI_O <= line_ctl_q[BIT_FORCE_AUI] || (line_ctl_q[BIT_AUTO_PORT] && !link_q);
			RX_LOW_SQUELCH_O <= line_ctl_q[BIT_LOW_SQUELCH];
		end
	end

	// ============================================================
	// report queues, one per source register
	logic [NUM_SRC-1:0] push, pop, avail;
	logic [9:0] push_bits [NUM_SRC];
	logic [9:0] front [NUM_SRC];
	logic [2:0] sel;

	assign push[0] = RX_FRAME_DONE_I && RX_DA_PASS_I && (|rx_bits);
	assign push_bits[0] = rx_bits;
	assign push[1] = TX_EVENT_I && (|TX_BITS_I);
	assign push_bits[1] = TX_BITS_I;
	assign push[2] = BUF_EVENT_I && (|BUF_BITS_I);
	assign push_bits[2] = BUF_BITS_I;
	assign push[3] = MISS_OVF_I && (|MISS_BITS_I);
	assign push_bits[3] = MISS_BITS_I;
	assign push[4] = COL_OVF_I && (|COL_BITS_I);
	assign push_bits[4] = COL_BITS_I;

	always_comb begin
		sel = 3'(NUM_SRC);
		for (int g = NUM_SRC - 1; g >= 0; g--) begin
			if (avail[g]) begin
				sel = 3'(g);
			end
		end
	end

	for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
		localparam int DEPTH = (g < 2) ? QDEPTH : 1;
		logic [9:0] q_q [QDEPTH];
		logic [9:0] q_d [QDEPTH];
		logic [2:0] cnt_q, cnt_d;

		assign pop[g] = (q_rd && sel == 3'(g)) || (mem_rd && HOST_ADDR_I == src_addr(g));
		assign avail[g] = cnt_q != 3'd0;
		assign front[g] = q_q[0];

		always_comb begin
			q_d = q_q;
			cnt_d = cnt_q;
			if (pop[g] && cnt_q != 3'd0) begin
				for (int i = 0; i < QDEPTH - 1; i++) begin
					q_d[i] = q_q[i + 1];
				end
				q_d[QDEPTH - 1] = '0;
				cnt_d = cnt_q - 3'd1;
			end
			if (push[g]) begin
				if (cnt_d == 3'(DEPTH)) begin
					q_d[DEPTH - 1] = q_d[DEPTH - 1] | push_bits[g];
				end else begin
					q_d[2'(cnt_d)] = push_bits[g];
					cnt_d = cnt_d + 3'd1;
				end
			end
		end

		always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
			if (!RESET_N_I) begin
				cnt_q <= '0;
				for (int i = 0; i < QDEPTH; i++) begin
					q_q[i] <= '0;
				end
			end else begin
				cnt_q <= cnt_d;
				q_q <= q_d;
			end
		end
	end

	// ============================================================
	// host read data
	logic [15:0] rd_word;

	always_comb begin
		rd_word = NULL_WORD;
		if (q_rd) begin
			if (sel != 3'(NUM_SRC)) begin
				rd_word = {front[sel], regnum(int'(sel))};
			end
		end else if (mem_rd) begin
			case (HOST_ADDR_I)
				ADDR_LINE_CTL: rd_word = line_ctl_q;
				ADDR_RX_ACCEPT: rd_word = rx_accept_q;
				ADDR_RX_CONFIG: rd_word = rx_config_q;
				ADDR_BUS_CTL: rd_word = bus_ctl_q;
				ADDR_INT_NUM: rd_word = {13'h0000, int_num_q};
				default: begin
					for (int g = 0; g < NUM_SRC; g++) begin
						if (HOST_ADDR_I == src_addr(g) && avail[g]) begin
							rd_word = {front[g], regnum(g)};
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			HOST_RDATA_O <= NULL_WORD;
		end else if (HOST_RD_I) begin
			HOST_RDATA_O <= rd_word;
		end
	end

	// ============================================================
	// interrupt line sequencing
	irq_state_t state_q;
	logic [7:0] hold_cnt_q;
	logic null_seen_q;

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state_q <= ST_IDLE;
			hold_cnt_q <= '0;
			null_seen_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if ((|avail) && gie) begin
						state_q <= ST_ASSERTED;
					end
				end
				ST_ASSERTED: begin
					if (q_rd) begin
						state_q <= ST_HOLD;
						hold_cnt_q <= HOLD_CYCLES - 8'd1;
						null_seen_q <= !(|avail);
					end else if (!gie) begin
						state_q <= ST_IDLE;
					end
				end
				ST_HOLD: begin
					if (hold_cnt_q != 8'd0) begin
						hold_cnt_q <= hold_cnt_q - 8'd1;
					end
					if (q_rd && !(|avail)) begin
						null_seen_q <= 1'b1;
					end
					if (hold_cnt_q == 8'd0 && (null_seen_q || (|avail))) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			IRQ_O <= '0;
			IRQ_OE_O <= '0;
		end else begin
			for (int i = 0; i < NUM_IRQ_LINES; i++) begin
				IRQ_OE_O[i] <= int_num_q == 3'(i);
				IRQ_O[i] <= int_num_q == 3'(i) && state_q == ST_ASSERTED;
			end
		end
	end

	// ============================================================
	// checks
	property p_raise;
		@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		(state_q == ST_IDLE && (|avail) && gie && int_num_q < INT_NUM_FLOAT) |=> ##1 (|IRQ_O);
	endproperty
	a_raise: assert property (p_raise) else $error("line not raised");

	property p_first_read_low;
		@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		(state_q == ST_ASSERTED && q_rd) |=> ##1 (IRQ_O == '0) [*8];
	endproperty
	a_first_read_low: assert property (p_first_read_low) else $error("line not held low");

	property p_hold_stays;
		@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		(state_q == ST_HOLD && hold_cnt_q != 8'd0) |=> state_q == ST_HOLD;
	endproperty
	a_hold_stays: assert property (p_hold_stays) else $error("hold left early");

	property p_single_buf;
		@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		(q_rd && sel == 3'd2 && !push[2]) |=> !avail[2];
	endproperty
	a_single_buf: assert property (p_single_buf) else $error("second buffer report");

	property p_rx_first;
		@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		(q_rd && avail[0]) |=> HOST_RDATA_O[5:0] == REGNUM_RX;
	endproperty
	a_rx_first: assert property (p_rx_first) else $error("priority broken");

	property p_null_word;
		@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		(q_rd && !(|avail)) |=> HOST_RDATA_O == NULL_WORD;
	endproperty
	a_null_word: assert property (p_null_word) else $error("empty queue not null");

	property p_float;
		@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		(int_num_q >= INT_NUM_FLOAT) |=> IRQ_OE_O == '0;
	endproperty
	a_float: assert property (p_float) else $error("line driven while floated");

	property p_gie;
		@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		(state_q == ST_IDLE && !gie) |=> state_q == ST_IDLE;
	endproperty
	a_gie: assert property (p_gie) else $error("interrupt without enable");

	property p_da_fail;
		@(posedge SYS_CLK_I) disable iff (!RESET_N_I)
		(RX_FRAME_DONE_I && !RX_DA_PASS_I) |-> !push[0];
	endproperty
	a_da_fail: assert property (p_da_fail) else $error("report for filtered frame");

endmodule : event_queue_rx_config

// [tb/event_host_model.sv]
// host model: register writes and queue reads over the same-clock strobe port
// assumes the device samples strobes on the rising edge of clk_i
module event_host_model
	import event_queue_pkg::*;
(
	input wire logic clk_i,
	output logic io_sel_o,
	output logic [11:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [15:0] wdata_o,
	input wire logic [15:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		io_sel_o = 1'b0;
		addr_o = 12'h000;
		rd_o = 1'b0;
		wr_o = 1'b0;
		wdata_o = 16'h0000;
	end

	// configuration only through internal-mode writes
	task automatic write_reg(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_i);
		io_sel_o <= 1'b0;
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask : write_reg

	task automatic read_reg(input logic io, input logic [11:0] a, output logic [15:0] d);
		@(posedge clk_i);
		io_sel_o <= io;
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		#1;
		d = rdata_i;
	endtask : read_reg

	// keeps reading until the empty marker, bounded
	task automatic drain(output int n);
		logic [15:0] w;
		n = 0;
		w = 16'hffff;
		while (w !== NULL_WORD && n < 16) begin
			read_reg(1'b0, ADDR_QUEUE, w);
			n++;
		end
	endtask : drain
endmodule : event_host_model

// [tb/tb_event_queue_rx_config.sv]
// testbench for the event report queue and receive configuration block
// assumes event_host_model drives the register port
module tb_event_queue_rx_config;
	import event_queue_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst_n, io_sel, rd, wr, fd, dap, crc_ok, link, ser, aui, sq, acc;
	logic [11:0] addr;
	logic [15:0] wdata, rdata, d;
	logic [3:0] flags, evp, irq, irq_oe;
	logic [9:0] evb [4];
	logic [10:0] rlen, xb, xp;
	int checks = 0;
	int bad_count = 0;
	int n;

	localparam logic [15:0] ACC_T [8] = '{16'h0180, 16'h0400, 16'h0500, 16'h0900,
		16'h1800, 16'h2080, 16'h0300, 16'h4080};
	localparam logic [3:0] CLS_T [8] = '{4'h0, 4'h2, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
	localparam logic [10:0] LEN_T [8] = '{11'd100, 11'd100, 11'd100, 11'd100,
		11'd100, 11'd40, 11'd61, 11'd1600};
	localparam logic [7:0] CRC_T = 8'b11100111;
	localparam logic [7:0] EXP_T = 8'b10110101;
	localparam logic [15:0] EXP_Q [6] = '{16'h0048, 16'h0088, 16'h030c, 16'h0090,
		16'h0052, 16'h0000};
	localparam logic [10:0] XB_T [8] = '{11'd96, 11'd96, 11'd96, 11'd96,
		11'd96, 11'd36, 11'd57, 11'd1514};
	localparam logic [10:0] XP_T [8] = '{11'd96, 11'd96, 11'd96, 11'd96,
		11'd96, 11'd36, 11'd60, 11'd1516};

	always #5 clk = ~clk;

	event_host_model host (.clk_i(clk), .io_sel_o(io_sel), .addr_o(addr), .rd_o(rd),
		.wr_o(wr), .wdata_o(wdata), .rdata_i(rdata));

	event_queue_rx_config dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .HOST_IO_SEL_I(io_sel),
		.HOST_ADDR_I(addr), .HOST_RD_I(rd), .HOST_WR_I(wr), .HOST_WDATA_I(wdata),
		.RX_FRAME_DONE_I(fd), .RX_DA_PASS_I(dap), .RX_IND_HASH_I(flags[3]),
		.RX_GROUP_HASH_I(flags[2]), .RX_OWN_MATCH_I(flags[1]), .RX_ALL_ONES_I(flags[0]),
		.RX_CRC_OK_I(crc_ok), .RX_LEN_I(rlen), .TX_EVENT_I(evp[0]), .TX_BITS_I(evb[0]),
		.BUF_EVENT_I(evp[1]), .BUF_BITS_I(evb[1]), .MISS_OVF_I(evp[2]),
		.MISS_BITS_I(evb[2]), .COL_OVF_I(evp[3]), .COL_BITS_I(evb[3]),
		.TP_LINK_OK_I(link), .HOST_RDATA_O(rdata), .IRQ_O(irq), .IRQ_OE_O(irq_oe),
		.RX_SERIAL_EN_O(ser), .RX_PORT_AUI_O(aui), .RX_LOW_SQUELCH_O(sq),
		.RX_ACCEPT_O(acc), .RX_XFER_BYTES_O(xb), .RX_XFER_PADDED_O(xp));

	// ============================================================
	// helpers
	task automatic test_done();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : cyc

	// index 0 tx, 1 buffer, 2 missed, 3 collision
	task automatic ev(input int s, input logic [9:0] b);
		@(posedge clk);
		evp[s] <= 1'b1;
		evb[s] <= b;
		@(posedge clk);
		evp[s] <= 1'b0;
		evb[s] <= ~b;
	endtask : ev

	task automatic frame(input logic da, input logic [3:0] c, input logic ok,
		input logic [10:0] l);
		@(posedge clk);
		fd <= 1'b1;
		dap <= da;
		flags <= c;
		crc_ok <= ok;
		rlen <= l;
		@(posedge clk);
		fd <= 1'b0;
		cyc(1);
	endtask : frame

	task automatic wait_irq(input int max, output int c);
		c = 0;
		while (irq[1] !== 1'b1 && c < max) begin
			cyc(1);
			c++;
		end
		if (irq[1] !== 1'b1) begin
			bad_count++;
			test_done();
		end
	endtask : wait_irq

	function automatic logic [10:0] xfer_len(input logic [10:0] l, input logic fcs);
		xfer_len = ((l > MAX_FRAME) ? MAX_FRAME : l) - (fcs ? 11'd0 : FCS_BYTES);
	endfunction : xfer_len

	// ============================================================
	// scenarios
	task automatic t_reset();
		chk(16'(irq_oe), 16'h0000);
		host.read_reg(1'b0, ADDR_LINE_CTL, d);
		chk(d, REG_RESET);
		host.read_reg(1'b0, 12'h3fe, d);
		chk(d, 16'h0000);
	endtask : t_reset

	task automatic t_line();
		@(posedge clk);
		link <= 1'b1;
		host.write_reg(ADDR_LINE_CTL, 16'h4340);
		cyc(2);
		chk(16'({ser, aui, sq}), 16'h0007);
		host.write_reg(ADDR_LINE_CTL, 16'h0200);
		cyc(6);
		chk(16'(aui), 16'h0000);
		@(posedge clk);
		link <= 1'b0;
		cyc(6);
		chk(16'(aui), 16'h0001);
		host.write_reg(ADDR_LINE_CTL, 16'h0000);
		cyc(2);
		chk(16'({ser, aui, sq}), 16'h0000);
	endtask : t_line

	task automatic t_no_global();
		host.write_reg(ADDR_INT_NUM, 16'h0001);
		host.write_reg(ADDR_RX_CONFIG, 16'h7100);
		frame(1'b1, 4'h0, 1'b1, 11'd100);
		cyc(6);
		chk(16'(irq), 16'h0000);
		chk(16'(irq_oe), 16'h0002);
		host.read_reg(1'b1, IO_QUEUE_OFS, d);
		chk(d, 16'h0104);
		host.read_reg(1'b1, IO_QUEUE_OFS, d);
		chk(d, NULL_WORD);
	endtask : t_no_global

	task automatic t_priority();
		host.write_reg(ADDR_BUS_CTL, 16'h8000);
		ev(3, 10'h001);
		wait_irq(4, n);
		chk(16'(irq), 16'h0002);
		ev(2, 10'h002);
		ev(1, 10'h004);
		ev(1, 10'h008);
		ev(0, 10'h001);
		ev(0, 10'h002);
		frame(1'b1, 4'h0, 1'b1, 11'd100);
		host.read_reg(1'b0, ADDR_QUEUE, d);
		chk(d, 16'h0104);
		chk(16'(irq), 16'h0000);
		for (int i = 0; i < 6; i++) begin
			host.read_reg(1'b0, ADDR_QUEUE, d);
			chk(d, EXP_Q[i]);
		end
		cyc(120);
		chk(16'(irq), 16'h0000);
	endtask : t_priority

	task automatic t_rearm();
		cyc(100);
		frame(1'b1, 4'h0, 1'b0, 11'd100);
		ev(0, 10'h3ff);
		wait_irq(4, n);
		host.read_reg(1'b0, ADDR_QUEUE, d);
		chk(d, 16'h1004);
		wait_irq(400, n);
		chk(16'(n >= HOLD_CYCLES - 4 && n <= HOLD_CYCLES + 8), 16'h0001);
		host.read_reg(1'b0, ADDR_QUEUE, d);
		chk(d, 16'hffc8);
		host.drain(n);
		chk(16'(n), 16'h0001);
	endtask : t_rearm

	task automatic t_filtered();
		cyc(170);
		frame(1'b0, 4'h0, 1'b1, 11'd100);
		cyc(4);
		chk(16'(irq), 16'h0000);
		host.write_reg(ADDR_RX_CONFIG, 16'h1000);
		frame(1'b1, 4'h0, 1'b1, 11'd100);
		host.read_reg(1'b0, ADDR_QUEUE, d);
		chk(d, NULL_WORD);
		ev(0, 10'h005);
		host.read_reg(1'b0, ADDR_TX_EVENT, d);
		chk(d, 16'h0148);
		host.read_reg(1'b0, ADDR_QUEUE, d);
		chk(d, NULL_WORD);
	endtask : t_filtered

	task automatic t_accept();
		host.write_reg(ADDR_RX_CONFIG, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			host.write_reg(ADDR_RX_ACCEPT, ACC_T[i]);
			frame(1'b1, CLS_T[i], CRC_T[i], LEN_T[i]);
			chk(16'(acc), 16'(EXP_T[i]));
			chk(16'(xb), 16'(XB_T[i]));
			chk(16'(xp), 16'(XP_T[i]));
		end
		host.write_reg(ADDR_RX_CONFIG, 16'h0800);
		frame(1'b1, 4'h0, 1'b1, 11'd61);
		chk(16'(xb), 16'(xfer_len(11'd61, 1'b1)));
		chk(16'(xp), 16'h0040);
	endtask : t_accept

	// ============================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		fd = 1'b0;
		dap = 1'b0;
		crc_ok = 1'b0;
		link = 1'b0;
		flags = 4'h0;
		evp = 4'h0;
		rlen = 11'h000;
		evb = '{default: 10'h000};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		t_reset();
		t_line();
		t_no_global();
		t_priority();
		t_rearm();
		t_filtered();
		t_accept();
		test_done();
	end
endmodule : tb_event_queue_rx_config
